// ===== core/tie_top.sv
// timer interrupt enable block: apb slave, six channels, summary irq
// assumes counters and compare/capture events run on pclk
`timescale 1ns/1ps
// Summary of operation
// - trigger enable gates converter start on a-event
// - enable bit 6 reads one, ignores writes
// - underflow enable gates underflow request
// - channels 0,3: no underflow bit or request
// - overflow enable gates overflow request
// - channels 0,3: enable d gates request d
// - other channels: no d bit or request
// - channels 0,3: enable c gates request c
// - other channels: no c bit or request
// - enable b gates request b
// - enable a gates request a
// - six independent channel copies
// - counter wraps set overflow/underflow flags
// - flag clears by zero write after one read
// - channels 0,3: d event sets flag d
module tie_top #(
  parameter int NUM_CH = 6
) (
  input wire logic pclk, // peripheral clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic [NUM_CH*16-1:0] channel_counter, // counter values, channel 0 lowest
  input wire logic [NUM_CH-1:0] cmp_cap_a_event, // compare/capture a pulses
  input wire logic [NUM_CH-1:0] cmp_cap_b_event, // compare/capture b pulses
  input wire logic [NUM_CH-1:0] cmp_cap_c_event, // compare/capture c pulses
  input wire logic [NUM_CH-1:0] cmp_cap_d_event, // compare/capture d pulses
  output logic [NUM_CH-1:0] underflow_irq_request, // underflow requests
  output logic [NUM_CH-1:0] overflow_irq_request, // overflow requests
  output logic [NUM_CH-1:0] cmp_cap_d_irq_request, // request d
  output logic [NUM_CH-1:0] cmp_cap_c_irq_request, // request c
  output logic [NUM_CH-1:0] cmp_cap_b_irq_request, // request b
  output logic [NUM_CH-1:0] cmp_cap_a_irq_request, // request a
  output logic [NUM_CH-1:0] conv_start_request, // converter start pulses
  output logic irq // summary interrupt, level
);
  if (NUM_CH < 1 || NUM_CH > tie_pkg::MAX_CH)
  begin : g_bad_param
    $error("NUM_CH must lie between 1 and 6");
  end

  tie_pkg::tie_apb_state_type state_reg;
  logic [31:0] rd_data;
  logic rd_err;
  logic done;
  logic [2:0] ch_sel;
  logic [NUM_CH-1:0] hit_en;
  logic [NUM_CH-1:0] hit_st;
  logic [NUM_CH-1:0] en_wr;
  logic [NUM_CH-1:0] st_wr;
  logic [NUM_CH-1:0] st_rd;
  logic [7:0] ch_data;
  logic [7:0] ch_en [NUM_CH];
  logic [7:0] ch_st [NUM_CH];
  logic [5:0] ch_req [NUM_CH];
  logic [NUM_CH-1:0] irq_status_reg;
  logic [NUM_CH-1:0] irq_mask_reg;
  logic hit_istat;
  logic hit_imask;

  assign ch_sel = paddr[6:4];
  assign hit_istat = (paddr == tie_pkg::OFS_IRQ_STATUS);
  assign hit_imask = (paddr == tie_pkg::OFS_IRQ_MASK);
  assign done = (state_reg == tie_pkg::ST_DONE);
  // reads hand the returned value to the channel for clear arming
  assign ch_data = pwrite ? pwdata[7:0] : prdata[7:0];

  always_comb
  begin
    hit_en = '0;
    hit_st = '0;
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (paddr[11:4] == 8'(c) && paddr[1:0] == 2'b00)
      begin
        hit_en[c] = (paddr[3:2] == tie_pkg::OFS_ENABLE[3:2]);
        hit_st[c] = (paddr[3:2] == tie_pkg::OFS_STATUS[3:2]);
      end
    end
  end

  assign en_wr = (done && pwrite) ? hit_en : '0;
  assign st_wr = (done && pwrite) ? hit_st : '0;
  assign st_rd = (done && !pwrite) ? hit_st : '0;

  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    if (hit_istat)
      rd_data = 32'(irq_status_reg);
    else if (hit_imask)
      rd_data = 32'(irq_mask_reg);
    else if (|hit_en)
      rd_data = 32'(ch_en[ch_sel]);
    else if (|hit_st)
      rd_data = 32'(ch_st[ch_sel]);
    else
      rd_err = 1'b1;
  end

  // one wait state, then the transfer completes with pready high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= tie_pkg::ST_IDLE;
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      case (state_reg)
        tie_pkg::ST_IDLE:
        begin
          if (psel && penable)
          begin
            state_reg <= tie_pkg::ST_DONE;
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0000_0000 : rd_data;
            pslverr <= rd_err;
          end
        end
        tie_pkg::ST_DONE:
        begin
          state_reg <= tie_pkg::ST_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
        default:
        begin
          state_reg <= tie_pkg::ST_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    localparam bit HAS_UD = (c % 3) != 0;
    tie_channel #(
      .HAS_UNDERFLOW(HAS_UD)
    ) u_ch (
      .clk(pclk),
      .rst_n(presetn),
      .en_wr(en_wr[c]),
      .st_wr(st_wr[c]),
      .st_rd(st_rd[c]),
      .data(ch_data),
      .count(channel_counter[c*16 +: 16]),
      .evt_a(cmp_cap_a_event[c]),
      .evt_b(cmp_cap_b_event[c]),
      .evt_c(cmp_cap_c_event[c]),
      .evt_d(cmp_cap_d_event[c]),
      .enable_value(ch_en[c]),
      .status_value(ch_st[c]),
      .req(ch_req[c]),
      .conv_req(conv_start_request[c])
    );
    assign underflow_irq_request[c] = ch_req[c][tie_pkg::BIT_UNDER];
    assign overflow_irq_request[c] = ch_req[c][tie_pkg::BIT_OVER];
    assign cmp_cap_d_irq_request[c] = ch_req[c][tie_pkg::BIT_D];
    assign cmp_cap_c_irq_request[c] = ch_req[c][tie_pkg::BIT_C];
    assign cmp_cap_b_irq_request[c] = ch_req[c][tie_pkg::BIT_B];
    assign cmp_cap_a_irq_request[c] = ch_req[c][tie_pkg::BIT_A];
  end

  // converter starts are the sticky events; write one to clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status_reg <= '0;
    else
      irq_status_reg <= conv_start_request |
        (irq_status_reg & ~((done && pwrite && hit_istat) ? pwdata[NUM_CH-1:0] : '0));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_reg <= '0;
    else if (done && pwrite && hit_imask)
      irq_mask_reg <= pwdata[NUM_CH-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(irq_status_reg & irq_mask_reg);
  end

  // status reads that returned flag a set, per channel, for the clear checks
  logic [NUM_CH-1:0] rd_one_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rd_one_reg <= '0;
    else
      rd_one_reg <= (rd_one_reg | (st_rd & {NUM_CH{prdata[0]}})) & ~st_wr;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_apb_wait_state: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not after one wait state");
  chk_irq_level: assert property (irq == $past(|(irq_status_reg & irq_mask_reg)))
    else $error("irq does not follow masked status");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_err_only_ready: assert property (!pready |-> !pslverr)
    else $error("pslverr outside a transfer answer");
  chk_unmapped_zero: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("unmapped access returned data");
  chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read data bits not zero");

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_chk
    chk_conv_gate: assert property (cmp_cap_a_event[c] |=> conv_start_request[c] == $past(ch_en[c][7]))
      else $error("converter start not gated by trigger enable");
    chk_conv_cause: assert property (!cmp_cap_a_event[c] |=> !conv_start_request[c])
      else $error("converter start without a-event");
    chk_rsvd_one: assert property (ch_en[c][6] && ch_st[c][6])
      else $error("reserved bit 6 not one");
    chk_ovf_request: assert property (overflow_irq_request[c] == $past(ch_st[c][4] & ch_en[c][4]))
      else $error("overflow request mismatch");
    chk_b_request: assert property (cmp_cap_b_irq_request[c] == $past(ch_st[c][1] & ch_en[c][1]))
      else $error("request b mismatch");
    chk_a_request: assert property (cmp_cap_a_irq_request[c] == $past(ch_st[c][0] & ch_en[c][0]))
      else $error("request a mismatch");
    chk_en_isolated: assert property (!en_wr[c] |=> $stable(ch_en[c]))
      else $error("enable changed without own write");
    chk_ovf_wrap: assert property ($past(presetn) && $past(channel_counter[c*16 +: 16]) == 16'hffff
      && channel_counter[c*16 +: 16] == 16'h0000 |=> ch_st[c][4])
      else $error("overflow wrap did not set flag");
    chk_flag_hold: assert property (ch_st[c][4] && !st_wr[c] |=> ch_st[c][4])
      else $error("overflow flag cleared without write");
    chk_clear_needs_read: assert property (ch_st[c][0] && st_wr[c] && !pwdata[0]
      && !rd_one_reg[c] |=> ch_st[c][0])
      else $error("flag cleared without prior read");
    chk_clear_after_read: assert property (ch_st[c][0] && st_wr[c] && !pwdata[0]
      && rd_one_reg[c] && !cmp_cap_a_event[c] |=> !ch_st[c][0])
      else $error("flag not cleared after read and zero write");
    chk_istat_set: assert property (conv_start_request[c] |=> irq_status_reg[c])
      else $error("converter start not recorded");
    chk_istat_clear: assert property (done && pwrite && hit_istat && pwdata[c]
      && !conv_start_request[c] |=> !irq_status_reg[c])
      else $error("status bit not cleared by one write");
    chk_a_flag_set: assert property (cmp_cap_a_event[c] |=> ch_st[c][0])
      else $error("a event did not set flag");
    chk_b_flag_set: assert property (cmp_cap_b_event[c] |=> ch_st[c][1])
      else $error("b event did not set flag");
    if (c % 3 != 0)
    begin : g_ud
      chk_udf_request: assert property (underflow_irq_request[c] == $past(ch_st[c][5] & ch_en[c][5]))
        else $error("underflow request mismatch");
      chk_no_cd: assert property (ch_en[c][3:2] == 2'b00 && ch_st[c][3:2] == 2'b00
        && !cmp_cap_d_irq_request[c] && !cmp_cap_c_irq_request[c])
        else $error("reserved c/d bit or request active");
      chk_udf_wrap: assert property ($past(presetn)
        && $past(channel_counter[c*16 +: 16]) == 16'h0000
        && channel_counter[c*16 +: 16] == 16'hffff |=> ch_st[c][5])
        else $error("underflow wrap did not set flag");
      chk_udf_hold: assert property (ch_st[c][5] && !st_wr[c] |=> ch_st[c][5])
        else $error("underflow flag cleared without write");
    end
    else
    begin : g_cd
      chk_no_udf: assert property (!ch_en[c][5] && !ch_st[c][5] && !underflow_irq_request[c])
        else $error("reserved underflow bit or request active");
      chk_d_request: assert property (cmp_cap_d_irq_request[c] == $past(ch_st[c][3] & ch_en[c][3]))
        else $error("request d mismatch");
      chk_c_request: assert property (cmp_cap_c_irq_request[c] == $past(ch_st[c][2] & ch_en[c][2]))
        else $error("request c mismatch");
      chk_d_flag_set: assert property (cmp_cap_d_event[c] |=> ch_st[c][3])
        else $error("d event did not set flag");
      chk_c_flag_set: assert property (cmp_cap_c_event[c] |=> ch_st[c][2])
        else $error("c event did not set flag");
      chk_d_flag_hold: assert property (ch_st[c][3] && !st_wr[c] |=> ch_st[c][3])
        else $error("d flag cleared without write");
    end
  end

  cov_conv_start: cover property (conv_start_request[0]);
  cov_irq_raised: cover property (!irq ##1 irq);
  cov_unmapped: cover property (pready && pslverr);
  cov_flag_clear: cover property (ch_st[0][0] ##1 !ch_st[0][0]);
  cov_underflow: cover property (underflow_irq_request[1]);
endmodule : tie_top

// ===== core/tie_pkg.sv
// constants of the per-channel timer interrupt enable block
// assumes a 32-bit apb slave port and six timer channels
package tie_pkg;
  localparam int MAX_CH = 6;
  localparam int CNT_W = 16;
  // register map, byte addresses
  localparam logic [11:0] CH_STRIDE = 12'h010;
  localparam logic [3:0] OFS_ENABLE = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h060;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h064;
  // field positions of enable and status registers
  localparam int BIT_CONV = 7;
  localparam int BIT_RSVD = 6;
  localparam int BIT_UNDER = 5;
  localparam int BIT_OVER = 4;
  localparam int BIT_D = 3;
  localparam int BIT_C = 2;
  localparam int BIT_B = 1;
  localparam int BIT_A = 0;
  // reset and mask values
  localparam logic [7:0] EN_RESET = 8'h40;
  localparam logic [7:0] EN_WMASK_UD = 8'hb3;
  localparam logic [7:0] EN_WMASK_CD = 8'h9f;
  localparam logic [5:0] FLAG_MASK_UD = 6'h33;
  localparam logic [5:0] FLAG_MASK_CD = 6'h1f;
  localparam logic [5:0] FLAG_RESET = 6'h00;
  localparam logic [1:0] STATUS_TOP = 2'h3;
  localparam logic [15:0] CNT_ALL_ONES = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_PREV_RESET = 16'h0001;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DONE = 2'b01
  } tie_apb_state_type;
endpackage : tie_pkg

// ===== core/tie_channel.sv
// one timer channel: enable register, status flags, gated requests
// assumes counter value and event pulses come from logic on clk
`timescale 1ns/1ps
module tie_channel #(
  parameter bit HAS_UNDERFLOW = 1'b1
) (
  input wire logic clk, // peripheral clock
  input wire logic rst_n, // async reset, active low
  input wire logic en_wr, // write enable register
  input wire logic st_wr, // write status register
  input wire logic st_rd, // status read completes
  input wire logic [7:0] data, // write data, or data just read
  input wire logic [15:0] count, // channel counter value
  input wire logic evt_a, // compare/capture a event
  input wire logic evt_b, // compare/capture b event
  input wire logic evt_c, // compare/capture c event
  input wire logic evt_d, // compare/capture d event
  output logic [7:0] enable_value, // enable register readback
  output logic [7:0] status_value, // status register readback
  output logic [5:0] req, // requests u,v,d,c,b,a
  output logic conv_req // converter start pulse
);
  localparam logic [7:0] WMASK = HAS_UNDERFLOW ? tie_pkg::EN_WMASK_UD : tie_pkg::EN_WMASK_CD;
  localparam logic [5:0] FMASK = HAS_UNDERFLOW ? tie_pkg::FLAG_MASK_UD : tie_pkg::FLAG_MASK_CD;

  logic [7:0] en_reg;
  logic [5:0] flag_reg;
  logic [5:0] flag_next;
  logic [5:0] armed_reg;
  logic [15:0] prev_reg;
  logic [5:0] set_vec;
  logic [5:0] clr_vec;
  logic ovf_set;
  logic udf_set;

  // reserved bits keep their fixed value
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      en_reg <= tie_pkg::EN_RESET;
    else if (en_wr)
      en_reg <= (data & WMASK) | (tie_pkg::EN_RESET & ~WMASK);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prev_reg <= tie_pkg::CNT_PREV_RESET;
    else
      prev_reg <= count;
  end

  assign ovf_set = (prev_reg == tie_pkg::CNT_ALL_ONES) && (count == tie_pkg::CNT_ZERO);
  assign udf_set = (prev_reg == tie_pkg::CNT_ZERO) && (count == tie_pkg::CNT_ALL_ONES);
  assign set_vec = {udf_set, ovf_set, evt_d, evt_c, evt_b, evt_a} & FMASK;
  // clear only bits read as one before the zero write
  assign clr_vec = st_wr ? (armed_reg & ~data[5:0]) : 6'h00;
  assign flag_next = (set_vec | (flag_reg & ~clr_vec)) & FMASK;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flag_reg <= tie_pkg::FLAG_RESET;
    else
      flag_reg <= flag_next;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      armed_reg <= 6'h00;
    else if (st_wr)
      armed_reg <= 6'h00;
    else if (st_rd)
      armed_reg <= armed_reg | (data[5:0] & flag_reg);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      req <= 6'h00;
    else
      req <= flag_reg & en_reg[5:0] & FMASK;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      conv_req <= 1'b0;
    else
      conv_req <= evt_a & en_reg[tie_pkg::BIT_CONV];
  end

  assign enable_value = en_reg;
  assign status_value = {tie_pkg::STATUS_TOP, flag_reg};
endmodule : tie_channel

// ===== dv/tie_irq_sink.sv
// model of the interrupt controller and converter trigger input
// assumes start pulses and the summary interrupt come from tie_top on pclk
`timescale 1ns/1ps
module tie_irq_sink (
  input wire logic pclk, // peripheral clock
  input wire logic presetn, // async reset, active low
  input wire logic [5:0] conv_start_request, // converter start pulses
  input wire logic irq, // summary interrupt
  output logic [47:0] conv_cnt, // starts seen, 8 bits a channel
  output logic irq_seen // summary interrupt latched
);
  // one count per cycle high, so a stretched pulse shows as extra starts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conv_cnt <= '0;
    else
      for (int c = 0; c < 6; c++)
        if (conv_start_request[c] === 1'b1)
          conv_cnt[c*8+:8] <= conv_cnt[c*8+:8] + 8'h01;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_seen <= 1'b0;
    else
      irq_seen <= irq_seen | (irq === 1'b1);
  end
endmodule : tie_irq_sink

// ===== dv/tb_timer_channel_irq_enable.sv
// self-checking bench: apb master, event driver, read-data scoreboard
// assumes tie_top with six channels and the tie_irq_sink model
`timescale 1ns/1ps
module tb_timer_channel_irq_enable;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [95:0] cnt = '0;
  logic [5:0] ev_a = '0, ev_b = '0, ev_c = '0, ev_d = '0;
  logic [5:0] un_rq, ov_rq, d_rq, c_rq, b_rq, a_rq, conv;
  logic irq;
  logic irq_seen;
  logic [47:0] conv_cnt;
  logic [32:0] exp_q[$];
  int error_cnt = 0;
  int n_compared = 0;
  logic [31:0] rng = 32'h62cef510;

  tie_top #(.NUM_CH(6)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .channel_counter(cnt), .cmp_cap_a_event(ev_a), .cmp_cap_b_event(ev_b),
    .cmp_cap_c_event(ev_c), .cmp_cap_d_event(ev_d), .underflow_irq_request(un_rq),
    .overflow_irq_request(ov_rq), .cmp_cap_d_irq_request(d_rq), .cmp_cap_c_irq_request(c_rq),
    .cmp_cap_b_irq_request(b_rq), .cmp_cap_a_irq_request(a_rq), .conv_start_request(conv),
    .irq(irq));
  tie_irq_sink sink (.pclk(pclk), .presetn(presetn), .conv_start_request(conv), .irq(irq),
    .conv_cnt(conv_cnt), .irq_seen(irq_seen));

  always #2 pclk = ~pclk;

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  // scoreboard: each completed read takes the oldest note
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0)
    begin
      if (exp_q.size() == 0)
        chk("unexpected read", 48'h1, 48'h0);
      else
        chk("read", {15'h0, pslverr, prdata}, {15'h0, exp_q.pop_front()});
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      chk("pready", 48'h0, 48'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic chk_req(input logic [35:0] e);
    chk("requests", {12'h0, un_rq, ov_rq, d_rq, c_rq, b_rq, a_rq}, {12'h0, e});
  endtask : chk_req

  initial
  begin
    #20000;
    error_cnt++;
    $display("watchdog expired");
    results();
  end

  initial
  begin
    logic [7:0] m;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int c = 0; c < 6; c++)
    begin
      rd(12'(c * 16), 33'h40);
      rd(12'(c * 16 + 4), 33'hc0);
    end
    chk_req(36'h0);
    $display("test reset done");
    for (int c = 0; c < 6; c++)
    begin
      m = (c == 0 || c == 3) ? tie_pkg::EN_WMASK_CD : tie_pkg::EN_WMASK_UD;
      rng = xorshift(rng);
      apb(1'b1, 12'(c * 16), rng);
      rd(12'(c * 16), {25'h0, (rng[7:0] & m) | 8'h40});
      apb(1'b1, 12'(c * 16), 32'hff);
      rd(12'(c * 16), {25'h0, 8'hff & m | 8'h40});
    end
    $display("test enable bits done");
    apb(1'b1, 12'h050, 32'h7f);
    apb(1'b1, 12'h064, 32'h01);
    @(posedge pclk);
    {ev_a, ev_b, ev_c, ev_d} <= {4{6'h3f}};
    cnt <= {6{16'hffff}};
    @(posedge pclk);
    {ev_a, ev_b, ev_c, ev_d} <= '0;
    cnt <= '0;
    @(posedge pclk);
    cnt <= {6{16'hffff}};
    repeat (5) @(posedge pclk);
    chk_req({6'h36, 6'h3f, 6'h09, 6'h09, 6'h3f, 6'h3f});
    chk("starts", conv_cnt, {8'h00, {5{8'h01}}});
    chk("irq", {47'h0, irq}, 48'h1);
    chk("irq seen", {47'h0, irq_seen}, 48'h1);
    rd(12'h060, 33'h1f);
    $display("test events done");
    apb(1'b1, 12'h020, 32'h00);
    apb(1'b1, 12'h000, 32'h01);
    repeat (2) @(posedge pclk);
    chk_req({6'h32, 6'h3a, 6'h08, 6'h08, 6'h3a, 6'h3b});
    apb(1'b1, 12'h014, 32'h00);
    rd(12'h014, 33'hf3);
    rd(12'h004, 33'hdf);
    apb(1'b1, 12'h004, 32'h00);
    rd(12'h004, 33'hc0);
    repeat (2) @(posedge pclk);
    chk_req({6'h32, 6'h3a, 6'h08, 6'h08, 6'h3a, 6'h3a});
    apb(1'b1, 12'h060, 32'h01);
    repeat (2) @(posedge pclk);
    chk("irq cleared", {47'h0, irq}, 48'h0);
    rd(12'h060, 33'h1e);
    $display("test clear done");
    @(posedge pclk);
    ev_a <= 6'h30;
    @(posedge pclk);
    ev_a <= 6'h00;
    repeat (3) @(posedge pclk);
    chk("gated starts", conv_cnt, {8'h00, 8'h02, {4{8'h01}}});
    rd(12'h0fc, {1'b1, 32'h0});
    rd(12'h068, {1'b1, 32'h0});
    @(posedge pclk);
    chk("notes left", 48'(exp_q.size()), 48'h0);
    $display("test trigger and unmapped done");
    results();
  end
endmodule : tb_timer_channel_irq_enable
